// *** rtl/fci_defines.vh ***
`ifndef FCI_DEFINES_VH
`define FCI_DEFINES_VH
// Array geometry
`define FCI_ADDR_W        19
`define FCI_BLOCK_SEL_LSB 16
// Unlock cycle addresses and codes
`define FCI_UNLOCK_ADDR1  19'h05555
`define FCI_UNLOCK_ADDR2  19'h02AAA
`define FCI_UNLOCK_DATA1  8'hAA
`define FCI_UNLOCK_DATA2  8'h55
// Setup and confirm codes
`define FCI_CMD_RESET     8'hF0
`define FCI_CMD_IDREAD    8'h90
`define FCI_CMD_PROGRAM   8'hA0
`define FCI_CMD_ERASE     8'h80
`define FCI_CMD_CHIPCONF  8'h10
`define FCI_CMD_BLKCONF   8'h30
`define FCI_CMD_SUSPEND   8'hB0
`define FCI_CMD_RESUME    8'h30
`define FCI_CMD_PWRDOWN   8'hC0
// Host operation codes on opCode
`define FCI_OP_READ       3'h0
`define FCI_OP_RESET      3'h1
`define FCI_OP_IDREAD     3'h2
`define FCI_OP_PROGRAM    3'h3
`define FCI_OP_BLKERASE   3'h4
`define FCI_OP_CHIPERASE  3'h5
`define FCI_OP_SUSPEND    3'h6
`define FCI_OP_RESUME     3'h7
// Bus cycle timing: each strobe phase 120 ns at 20 ns clock
`define FCI_PHASE_NS      120
`define FCI_CLK_NS        20
`define FCI_PHASE_CYC     ((`FCI_PHASE_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`endif

// *** rtl/fci_bus_cycle.v ***
`timescale 1ns/10ps
`include "fci_defines.vh"
// One asynchronous bus cycle: setup, strobe low, strobe high, then idle.
module fci_bus_cycle #(
  parameter PHASE = `FCI_PHASE_CYC
) (
  // Clock and reset
  input  wire                   clk_sys,
  input  wire                   resetn,
  // Request
  input  wire                   start,
  input  wire                   isWrite,
  input  wire [`FCI_ADDR_W-1:0] addrIn,
  input  wire [7:0]             dataIn,
  // Completion
  output reg                    done,
  output reg  [7:0]             readData,
  // Pins
  output reg  [`FCI_ADDR_W-1:0] flashAddr,
  output reg                    chipSelN,
  output reg                    outGateN,
  output reg                    writeStrobeN,
  output reg  [7:0]             dqOut,
  output reg                    dqOe,
  input  wire [7:0]             dqSync
);
  localparam S_IDLE = 4'b0001;
  localparam S_SET  = 4'b0010;
  localparam S_STB  = 4'b0100;
  localparam S_HOLD = 4'b1000;
  reg [3:0] state;    // One-hot phase
  reg [7:0] cnt;      // Phase counter
  reg       wrMode;   // Latched direction
  ////////////////////////////////////////////////////////////////
  // Phase sequencer; address stands before strobe falls, data stays past rise
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state        <= S_IDLE;
      cnt          <= 8'h00;
      wrMode       <= 1'b0;
      done         <= 1'b0;
      readData     <= 8'h00;
      flashAddr    <= {`FCI_ADDR_W{1'b0}};
      chipSelN     <= 1'b1;
      outGateN     <= 1'b1;
      writeStrobeN <= 1'b1;
      dqOut        <= 8'h00;
      dqOe         <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (start)
          begin
            // Address and data set up ahead of strobe edge
            wrMode    <= isWrite;
            flashAddr <= addrIn;
            dqOut     <= dataIn;
            dqOe      <= isWrite;
            chipSelN  <= 1'b0;
            cnt       <= PHASE[7:0];
            state     <= S_SET;
          end
        end
        S_SET:
        begin
          if (cnt == 8'h01)
          begin
            // Falling strobe captures the address
            writeStrobeN <= ~wrMode;
            outGateN     <= wrMode;
            cnt          <= PHASE[7:0];
            state        <= S_STB;
          end
          else
            cnt <= cnt - 8'h01;
        end
        S_STB:
        begin
          if (cnt == 8'h01)
          begin
            // Rising strobe captures data; sample read data before releasing gate
            writeStrobeN <= 1'b1;
            outGateN     <= 1'b1;
            readData     <= dqSync;
            cnt          <= PHASE[7:0];
            state        <= S_HOLD;
          end
          else
            cnt <= cnt - 8'h01;
        end
        S_HOLD:
        begin
          if (cnt == 8'h01)
          begin
            // Data held past the rising edge, then bus released
            dqOe     <= 1'b0;
            chipSelN <= 1'b1;
            done     <= 1'b1;
            state    <= S_IDLE;
          end
          else
            cnt <= cnt - 8'h01;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // fci_bus_cycle

// *** rtl/fci_host_ctrl.v ***
// Contract
// - Commands need complete four or six writes; reset and id read here send three writes, suspend and resume one
// - Cycles 1,2,4,5 carry fixed unlock
// - Program: address and data on cycle four
// - Erase: second unlock, confirm on six
// - Address on strobe fall, data on rise
`timescale 1ns/10ps
`include "fci_defines.vh"
module fci_host_ctrl #(
  parameter PHASE    = `FCI_PHASE_CYC,
  parameter POLL_MAX = 32'd100000000
) (
  // Clock and reset
  input  wire                   clk_sys,
  input  wire                   resetn,
  // User request
  input  wire                   opValid,
  input  wire [2:0]             opCode,
  input  wire [`FCI_ADDR_W-1:0] opAddr,
  input  wire [7:0]             opData,
  output reg                    opReady,
  // User answer
  output reg                    respValid,
  output reg  [7:0]             respData,
  output reg                    respTimeout,
  // Flash pins
  output wire [`FCI_ADDR_W-1:0] byteAddressLines,
  output wire                   chipSelN,
  output wire                   outGateN,
  output wire                   writeStrobeN,
  output wire [7:0]             bidirDataLinesOut,
  output wire                   bidirDataLinesOe,
  input  wire [7:0]             bidirDataLinesIn
);
  localparam S_IDLE = 5'b00001;
  localparam S_SEQ  = 5'b00010;
  localparam S_WAIT = 5'b00100;
  localparam S_POLL = 5'b01000;
  localparam S_DONE = 5'b10000;
  reg [4:0]             state;       // One-hot control state
  reg [2:0]             idx;         // Current write cycle index
  reg [2:0]             nCyc;        // Writes in this sequence
  reg [2:0]             op;          // Latched operation
  reg [`FCI_ADDR_W-1:0] addrQ;       // Latched target address
  reg [7:0]             dataQ;       // Latched data
  reg                   started;     // Bus cycle launched
  reg                   cycRead;     // Current cycle is a read
  reg [7:0]             prevPoll;    // Previous status read
  reg                   havePrev;    // First poll read taken
  reg [31:0]            pollCnt;     // Poll time budget
  reg [7:0]             dqMeta;      // Synchroniser stage one
  reg [7:0]             dqSync;      // Synchroniser stage two
  reg [`FCI_ADDR_W-1:0] cAddr;       // Address of this write
  reg [7:0]             cData;       // Data of this write
  wire                  cycDone;     // Bus cycle complete
  wire [7:0]            cycData;     // Bus cycle read data
  ////////////////////////////////////////////////////////////////
  // Pin input synchroniser, two stages before any use
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      dqMeta <= 8'h00;
      dqSync <= 8'h00;
    end
    else
    begin
      dqMeta <= bidirDataLinesIn;
      dqSync <= dqMeta;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Address and data of each write in the sequence
  always @*
  begin
    cAddr = `FCI_UNLOCK_ADDR1;
    cData = `FCI_UNLOCK_DATA1;
    case (idx)
      3'd0, 3'd3:
      begin
        // Unlock first half, same for every multi-write instruction except program's fourth write
        cAddr = `FCI_UNLOCK_ADDR1;
        cData = `FCI_UNLOCK_DATA1;
      end
      3'd1, 3'd4:
      begin
        // Unlock second half
        cAddr = `FCI_UNLOCK_ADDR2;
        cData = `FCI_UNLOCK_DATA2;
      end
      3'd2:
      begin
        // Setup code selects the operation
        cAddr = `FCI_UNLOCK_ADDR1;
        case (op)
          `FCI_OP_RESET:     cData = `FCI_CMD_RESET;
          `FCI_OP_IDREAD:    cData = `FCI_CMD_IDREAD;
          `FCI_OP_PROGRAM:   cData = `FCI_CMD_PROGRAM;
          `FCI_OP_BLKERASE:  cData = `FCI_CMD_ERASE;
          `FCI_OP_CHIPERASE: cData = `FCI_CMD_ERASE;
          default:           cData = `FCI_CMD_RESET;
        endcase
      end
      3'd5:
      begin
        // Erase confirm: block address or chip-wide
        cAddr = (op == `FCI_OP_BLKERASE) ? addrQ : `FCI_UNLOCK_ADDR1;
        cData = (op == `FCI_OP_BLKERASE) ? `FCI_CMD_BLKCONF : `FCI_CMD_CHIPCONF;
      end
      default:
      begin
        cAddr = addrQ;
        cData = dataQ;
      end
    endcase
    // Program target on the fourth write
    if (op == `FCI_OP_PROGRAM && idx == 3'd3)
    begin
      cAddr = addrQ;
      cData = dataQ;
    end
    // Single-write suspend and resume
    if (op == `FCI_OP_SUSPEND)
    begin
      cAddr = addrQ;
      cData = `FCI_CMD_SUSPEND;
    end
    if (op == `FCI_OP_RESUME)
    begin
      cAddr = addrQ;
      cData = `FCI_CMD_RESUME;
    end
    // Plain reads use the user's address
    if (cycRead)
      cAddr = addrQ;
  end
  ////////////////////////////////////////////////////////////////
  // Shared bus cycle engine; keeps strobe timing in one place
  fci_bus_cycle #(
    .PHASE        (PHASE)
  ) u_cycle (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .start        (started),
    .isWrite      (~cycRead),
    .addrIn       (cAddr),
    .dataIn       (cData),
    .done         (cycDone),
    .readData     (cycData),
    .flashAddr    (byteAddressLines),
    .chipSelN     (chipSelN),
    .outGateN     (outGateN),
    .writeStrobeN (writeStrobeN),
    .dqOut        (bidirDataLinesOut),
    .dqOe         (bidirDataLinesOe),
    .dqSync       (dqSync)
  );
  ////////////////////////////////////////////////////////////////
  // Command sequencer: whole sequences only, never abandoned midway
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state       <= S_IDLE;
      idx         <= 3'd0;
      nCyc        <= 3'd0;
      op          <= `FCI_OP_READ;
      addrQ       <= {`FCI_ADDR_W{1'b0}};
      dataQ       <= 8'h00;
      started     <= 1'b0;
      cycRead     <= 1'b0;
      prevPoll    <= 8'h00;
      havePrev    <= 1'b0;
      pollCnt     <= 32'd0;
      opReady     <= 1'b0;
      respValid   <= 1'b0;
      respData    <= 8'h00;
      respTimeout <= 1'b0;
    end
    else
    begin
      started   <= 1'b0;
      respValid <= 1'b0;
      case (state)
        S_IDLE:
        begin
          opReady <= 1'b1;
          if (opValid && opReady)
          begin
            opReady     <= 1'b0;
            op          <= opCode;
            addrQ       <= opAddr;
            dataQ       <= opData;
            idx         <= 3'd0;
            respTimeout <= 1'b0;
            started     <= 1'b1;
            // Only plain reads are single read cycles; id read is a three-write sequence
            cycRead     <= (opCode == `FCI_OP_READ);
            case (opCode)
              `FCI_OP_READ, `FCI_OP_SUSPEND, `FCI_OP_RESUME: nCyc <= 3'd1;
              `FCI_OP_RESET, `FCI_OP_IDREAD:                  nCyc <= 3'd3;
              `FCI_OP_PROGRAM:                                 nCyc <= 3'd4;
              default:                                         nCyc <= 3'd6;
            endcase
            state <= S_SEQ;
          end
        end
        S_SEQ:
        begin
          if (cycDone)
          begin
            if (idx + 3'd1 < nCyc)
            begin
              idx     <= idx + 3'd1;
              started <= 1'b1;
            end
            else if (cycRead)
            begin
              // Read result goes straight to the user
              respData  <= cycData;
              respValid <= 1'b1;
              state     <= S_IDLE;
            end
            else if (op == `FCI_OP_PROGRAM || op == `FCI_OP_BLKERASE ||
                     op == `FCI_OP_CHIPERASE || op == `FCI_OP_RESUME)
            begin
              // Engine runs alone; host only polls
              havePrev <= 1'b0;
              pollCnt  <= POLL_MAX;
              cycRead  <= 1'b1;
              started  <= 1'b1;
              state    <= S_POLL;
            end
            else
            begin
              respData  <= 8'h00;
              respValid <= 1'b1;
              state     <= S_IDLE;
            end
          end
        end
        S_POLL:
        begin
          if (cycDone)
          begin
            prevPoll <= cycData;
            havePrev <= 1'b1;
            // Toggle bit steady means engine idle: done
            if (havePrev && (cycData[6] == prevPoll[6]))
            begin
              respData  <= cycData;
              respValid <= 1'b1;
              state     <= S_IDLE;
            end
            else if (pollCnt == 32'd0)
            begin
              // Budget spent, well above typical; refused blocks end above on a steady toggle bit
              respTimeout <= 1'b1;
              respData    <= cycData;
              respValid   <= 1'b1;
              state       <= S_IDLE;
            end
            else
              started <= 1'b1;
          end
          if (pollCnt != 32'd0)
            pollCnt <= pollCnt - 32'd1;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // fci_host_ctrl

// *** verification/fci_host_ctrl_assertions.sv ***
`timescale 1ns/10ps
`include "fci_defines.vh"
////////////////////////////////////////////////////////////
// Pin-level checks on the flash controller
module fci_host_chk #(
  parameter PHASE    = 6,
  parameter POLL_MAX = 2000
) (
  // Clock and reset
  input wire                   clk_sys,
  input wire                   resetn,
  // User side
  input wire                   opValid,
  input wire [2:0]             opCode,
  input wire [`FCI_ADDR_W-1:0] opAddr,
  input wire [7:0]             opData,
  input wire                   opReady,
  input wire                   respValid,
  input wire [7:0]             respData,
  input wire                   respTimeout,
  // Flash pins
  input wire [`FCI_ADDR_W-1:0] byteAddressLines,
  input wire                   chipSelN,
  input wire                   outGateN,
  input wire                   writeStrobeN,
  input wire [7:0]             bidirDataLinesOut,
  input wire                   bidirDataLinesOe,
  input wire [7:0]             bidirDataLinesIn
);
  reg [2:0] opQ;      // Op in flight
  reg [3:0] wrCnt_q;  // Write strobes since accept
  reg [3:0] rdCnt_q;  // Read gates since accept, saturating
  reg [8:0] lowCnt_q; // Cycles of the current write strobe
  // Write cycles each op must spend
  function [3:0] wants(input [2:0] c);
    case (c)
      `FCI_OP_READ:                       wants = 4'h0;
      `FCI_OP_PROGRAM:                    wants = 4'h4;
      `FCI_OP_BLKERASE, `FCI_OP_CHIPERASE: wants = 4'h6;
      `FCI_OP_SUSPEND, `FCI_OP_RESUME:    wants = 4'h1;
      default:                            wants = 4'h3;
    endcase
  endfunction
  // Write and read counters restart at each accept so a stray extra cycle shows
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      opQ      <= 3'h0;
      wrCnt_q  <= 4'h0;
      rdCnt_q  <= 4'h0;
      lowCnt_q <= 9'h000;
    end
    else
    begin
      lowCnt_q <= writeStrobeN ? 9'h000 : lowCnt_q + 9'h001;
      if (opValid && opReady)
      begin
        opQ     <= opCode;
        wrCnt_q <= 4'h0;
        rdCnt_q <= 4'h0;
      end
      else
      begin
        if ($fell(writeStrobeN)) wrCnt_q <= wrCnt_q + 4'h1;
        if ($fell(outGateN) && rdCnt_q != 4'hF) rdCnt_q <= rdCnt_q + 4'h1;
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Edges of a write strobe
  sequence wrFall;
    $fell(writeStrobeN);
  endsequence
  sequence wrRise;
    $rose(writeStrobeN);
  endsequence
  no_fight_a: assert property (!outGateN |-> !bidirDataLinesOe)
    else $error("controller drives data while gate low");
  one_strobe_a: assert property (!(!outGateN && !writeStrobeN))
    else $error("gate and write strobe low together");
  strobe_sel_a: assert property ((!writeStrobeN || !outGateN) |-> !chipSelN)
    else $error("strobe without chip select");
  addr_fall_a: assert property (wrFall |-> $stable(byteAddressLines) && bidirDataLinesOe)
    else $error("address or data not set before strobe fall");
  data_rise_a: assert property (wrRise |-> $stable(bidirDataLinesOut) && lowCnt_q == PHASE)
    else $error("data moved or strobe width wrong");
  resp_pulse_a: assert property (respValid |=> !respValid)
    else $error("answer longer than one cycle");
  ready_back_a: assert property (respValid |-> ##[1:2] opReady)
    else $error("ready not back after answer");
  taken_busy_a: assert property (opValid && opReady |=> !opReady)
    else $error("ready stayed high after accept");
  write_count_a: assert property (respValid |-> wrCnt_q == wants(opQ))
    else $error("wrong number of write cycles");
  poll_reads_a: assert property (respValid && opQ == `FCI_OP_PROGRAM |-> rdCnt_q >= 4'h2)
    else $error("program ended without polling");
endmodule // fci_host_chk

bind fci_host_ctrl fci_host_chk #(.PHASE(PHASE), .POLL_MAX(POLL_MAX)) chk (
  .clk_sys(clk_sys), .resetn(resetn), .opValid(opValid), .opCode(opCode), .opAddr(opAddr),
  .opData(opData), .opReady(opReady), .respValid(respValid), .respData(respData),
  .respTimeout(respTimeout), .byteAddressLines(byteAddressLines), .chipSelN(chipSelN),
  .outGateN(outGateN), .writeStrobeN(writeStrobeN), .bidirDataLinesOut(bidirDataLinesOut),
  .bidirDataLinesOe(bidirDataLinesOe), .bidirDataLinesIn(bidirDataLinesIn));

// *** verification/fci_flash_model.sv ***
`timescale 1ns/10ps
`include "fci_defines.vh"
////////////////////////////////////////////////////////////
// Behavioural flash on the far side of the pins
module fci_flash_model #(
  parameter [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter [7:0] PART_ID  = 8'hC3, // Arbitrary value
  parameter [7:0] GUARD    = 8'h04, // One protect bit per block
  parameter       BUSY_RD  = 4      // Status reads while busy; short stand-in for typical job time
) (
  // Pins from the controller
  input  wire [18:0] byteAddressLines,
  input  wire        chipSelN,
  input  wire        outGateN,
  input  wire        writeStrobeN,
  input  wire [7:0]  dqLine,
  // Data driver
  output reg  [7:0]  dqDrv,
  output reg         dqEn
);
  logic [7:0]  mem [int]; // Written bytes; the rest read erased
  reg   [18:0] la;        // Address taken at strobe fall
  reg   [7:0]  tgt;       // Final value of the running job
  reg   [2:0]  step;      // Position in the command sequence
  reg          idMode;    // Signature reads active
  reg          susp;      // Running job held
  reg          tog;       // Toggle bit
  integer      busy;      // Reads left before ready
  // Unwritten bytes read as erased
  function [7:0] rd(input [18:0] a);
    rd = mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // Power-up lands in array read
  initial
  begin
    {step, idMode, susp, tog, dqEn, dqDrv} = 0;
    busy = 0;
  end
  // Address latch
  always @(negedge writeStrobeN)
    if (!chipSelN) la = byteAddressLines;
  // Decoder; data taken at strobe rise, timing done here alone
  always @(posedge writeStrobeN)
  begin
    if (!chipSelN)
    begin
      case (step)
        0: if (la == `FCI_UNLOCK_ADDR1 && dqLine == `FCI_UNLOCK_DATA1) step = 1;
           else if (dqLine == `FCI_CMD_SUSPEND && busy > 0) susp = 1;
           else if (dqLine == `FCI_CMD_RESUME) susp = 0;
        1, 5: step = (la == `FCI_UNLOCK_ADDR2 && dqLine == `FCI_UNLOCK_DATA2) ? step + 3'h1 : 3'h0;
        4: step = (la == `FCI_UNLOCK_ADDR1 && dqLine == `FCI_UNLOCK_DATA1) ? 3'h5 : 3'h0;
        2:
        begin
          step = 0;
          if (la == `FCI_UNLOCK_ADDR1)
            case (dqLine)
              `FCI_CMD_RESET:   idMode = 0;
              `FCI_CMD_IDREAD:  idMode = 1;
              `FCI_CMD_PROGRAM: step = 3;
              `FCI_CMD_ERASE:   step = 4;
              default:          step = 0;
            endcase
        end
        3:
        begin
          step = 0;
          if (!GUARD[la[18:16]])
          begin
            mem[la] = rd(la) & dqLine;
            tgt = mem[la];
            busy = BUSY_RD;
          end
        end
        default:
        begin
          step = 0;
          tgt = 8'hFF;
          if (dqLine == `FCI_CMD_BLKCONF || dqLine == `FCI_CMD_CHIPCONF)
          begin
            busy = BUSY_RD;
            foreach (mem[k])
              if (!GUARD[k[18:16]] && (dqLine == `FCI_CMD_CHIPCONF || k[18:16] == la[18:16]))
                mem[k] = 8'hFF;
          end
        end
      endcase
    end
  end
  // Read side: status while busy and not suspended, else signature or array
  always @(negedge outGateN)
  begin
    if (!chipSelN)
    begin
      if (busy > 0 && !susp)
      begin
        dqDrv = {~tgt[7], tog, 6'h00};
        tog = ~tog;
        busy = busy - 1;
      end
      else if (idMode)
        dqDrv = byteAddressLines[1] ? {7'h00, GUARD[byteAddressLines[18:16]]} :
                byteAddressLines[0] ? PART_ID : MAKER_ID;
      else
        dqDrv = rd(byteAddressLines);
      dqEn = 1;
    end
  end
  // Let go as soon as gate or select goes away
  always @(posedge outGateN or posedge chipSelN)
    dqEn = 0;
endmodule // fci_flash_model

// *** verification/fci_host_ctrl_test.sv ***
`timescale 1ns/10ps
`include "fci_defines.vh"
////////////////////////////////////////////////////////////
// Controller against a behavioural flash
module fci_host_ctrl_test;
  localparam [7:0] MAKER = 8'h5A; // Arbitrary value
  localparam [7:0] PART  = 8'hC3; // Arbitrary value
  reg         clk_sys     = 1'b0;
  reg         resetn      = 1'b0;
  reg         opValid     = 1'b0;
  reg  [2:0]  opCode      = 3'h0;
  reg  [18:0] opAddr      = 19'h00000;
  reg  [7:0]  opData      = 8'h00;
  wire        opReady, respValid, respTimeout, chipSelN, outGateN, writeStrobeN, dqOe, mdlEn;
  wire [7:0]  respData, dqOut, mdlDrv;
  wire [18:0] addrPins;
  // Released bus shows a pattern that changes every cycle
  reg  [7:0]  flt         = 8'hA5;
  wire [7:0]  dqLine      = dqOe ? dqOut : mdlEn ? mdlDrv : flt;
  reg  [7:0]  expQ [$];   // Expected answers in order
  reg  [7:0]  lfsr        = 8'h26;
  reg  [18:0] pa;
  reg  [7:0]  pd;
  integer     fail_count  = 0;
  integer     checks_done = 0;
  integer     i;
  fci_host_ctrl #(.PHASE(6), .POLL_MAX(2000)) DUT (
    .clk_sys(clk_sys), .resetn(resetn), .opValid(opValid), .opCode(opCode), .opAddr(opAddr),
    .opData(opData), .opReady(opReady), .respValid(respValid), .respData(respData),
    .respTimeout(respTimeout), .byteAddressLines(addrPins), .chipSelN(chipSelN), .outGateN(outGateN),
    .writeStrobeN(writeStrobeN), .bidirDataLinesOut(dqOut), .bidirDataLinesOe(dqOe),
    .bidirDataLinesIn(dqLine));
  fci_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) mdl (
    .byteAddressLines(addrPins), .chipSelN(chipSelN), .outGateN(outGateN),
    .writeStrobeN(writeStrobeN), .dqLine(dqLine), .dqDrv(mdlDrv), .dqEn(mdlEn));
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) flt <= ~flt;
  function [7:0] nxt(input [7:0] v);
    nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One request: hold it until taken, note the answer, wait for it
  task op(input [2:0] c, input [18:0] a, input [7:0] d, input [7:0] e);
    integer n;
    opValid <= 1'b1;
    opCode <= c;
    opAddr <= a;
    opData <= d;
    n = 0;
    do @(posedge clk_sys); while (opReady !== 1'b1 && ++n < 6000);
    expQ.push_back(e);
    opValid <= 1'b0;
    do @(posedge clk_sys); while (respValid !== 1'b1 && ++n < 12000);
    if (n >= 6000)
    begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
  endtask
  // Watcher: each answer against the oldest note
  always @(posedge clk_sys)
  begin
    if (resetn && respValid === 1'b1)
    begin
      if (expQ.size() == 0) expQ.push_back(8'hEE);
      chk("respTimeout", {7'h00, respTimeout}, 8'h00);
      chk("respData", respData, expQ.pop_front());
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    op(`FCI_OP_READ, 19'h00000, 8'h00, 8'hFF);
    for (i = 0; i < 3; i = i + 1)
    begin
      lfsr = nxt(lfsr);
      pa = 19'h10000 + 19'(i * 256) + {11'h000, lfsr};
      lfsr = nxt(lfsr);
      pd = lfsr;
      op(`FCI_OP_PROGRAM, pa, pd, pd);
      op(`FCI_OP_READ, pa, 8'h00, pd);
    end
    op(`FCI_OP_PROGRAM, 19'h00077, 8'h3C, 8'h3C);
    op(`FCI_OP_PROGRAM, 19'h20010, 8'h00, 8'hFF);
    op(`FCI_OP_READ, 19'h20010, 8'h00, 8'hFF);
    op(`FCI_OP_IDREAD, 19'h00000, 8'h00, 8'h00);
    op(`FCI_OP_READ, 19'h00000, 8'h00, MAKER);
    op(`FCI_OP_READ, 19'h00001, 8'h00, PART);
    op(`FCI_OP_READ, 19'h20002, 8'h00, 8'h01);
    op(`FCI_OP_READ, 19'h00002, 8'h00, 8'h00);
    op(`FCI_OP_RESET, 19'h00000, 8'h00, 8'h00);
    op(`FCI_OP_READ, 19'h00077, 8'h00, 8'h3C);
    op(`FCI_OP_BLKERASE, 19'h00000, 8'h00, 8'hFF);
    op(`FCI_OP_READ, 19'h00077, 8'h00, 8'hFF);
    op(`FCI_OP_READ, pa, 8'h00, pd);
    op(`FCI_OP_SUSPEND, 19'h00000, 8'h00, 8'h00);
    op(`FCI_OP_RESUME, 19'h00000, 8'h00, 8'hFF);
    op(`FCI_OP_CHIPERASE, 19'h05555, 8'h00, 8'hFF);
    op(`FCI_OP_READ, pa, 8'h00, 8'hFF);
    @(posedge clk_sys);
    report_and_stop;
  end
endmodule // fci_host_ctrl_test
